// >>> oag_pkg.sv
// Package for operand address generation: field layout, modes, steps,
// addressing times and the instruction group decoder.
// Assumes a 16-bit word machine with eight general registers.
`default_nettype none

package oag_pkg;

    typedef enum logic [2:0] {
        GRP_SINGLE,
        GRP_DOUBLE,
        GRP_CONTROL,
        GRP_OPERATE,
        GRP_CCODE
    } oag_group_t;

    // Field positions inside the instruction word
    localparam int SRC_LSB = 6;
    localparam int DST_LSB = 0;
    localparam int BYTE_BIT = 15;
    localparam int DEFER_BIT = 0;

    // Addressing kind, held in mode bits 2:1
    localparam logic [1:0] KIND_REG = 2'h0;
    localparam logic [1:0] KIND_AINC = 2'h1;
    localparam logic [1:0] KIND_ADEC = 2'h2;
    localparam logic [1:0] KIND_INDEX = 2'h3;

    localparam logic [2:0] REG_SIX = 3'h6;
    localparam logic [2:0] REG_PC = 3'h7;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Opcode patterns used by the group decoder and the decode in oag_top
    localparam logic [2:0] OPF_NO_DBL = 3'h0;
    localparam logic [2:0] OPF_EXT_DBL = 3'h7;
    localparam logic [2:0] OPF_SUB = 3'h6;
    localparam logic [2:0] OPF_SGL_A = 3'h5;
    localparam logic [2:0] OPF_SGL_B = 3'h6;
    localparam logic [5:0] OPF_SWAB = 6'h03;
    localparam logic [5:0] OPF_JMP = 6'h01;
    localparam logic [5:0] OPF_CALL_TRAP = 6'h04;
    localparam logic [8:0] OPF_RETURN = 9'h010;
    localparam logic [6:0] OPF_CCODE = 7'h05;

    // Addressing time per mode in ns, source and destination
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SRC_TIME_NS [8] =
        '{0, 900, 900, 2400, 900, 2400, 2400, 3400};
    localparam int unsigned DST_TIME_NS [8] =
        '{0, 2400, 2400, 3400, 2400, 3400, 3400, 4700};

    function automatic int unsigned oag_ns_to_cycles(int unsigned ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : oag_ns_to_cycles

    function automatic logic [15:0] oag_addr_cycles(logic [2:0] mode,
                                                    logic dst);
        return 16'(oag_ns_to_cycles(dst ? DST_TIME_NS[mode]
                                        : SRC_TIME_NS[mode]));
    endfunction : oag_addr_cycles

    function automatic oag_group_t oag_decode_group(logic [15:0] w);
        if (w[14:12] != OPF_NO_DBL && w[14:12] != OPF_EXT_DBL)
            return GRP_DOUBLE;
        if (w[14:12] != OPF_NO_DBL)
            return GRP_OPERATE;
        if (w[11:9] == OPF_SGL_A || (w[11:9] == OPF_SGL_B && !w[8]) ||
            (!w[15] && w[11:6] == OPF_SWAB))
            return GRP_SINGLE;
        if (!w[15] && w[11:5] == OPF_CCODE)
            return GRP_CCODE;
        if (w[11:8] != 4'h0 || (!w[15] && (w[11:6] == OPF_JMP ||
            w[11:3] == OPF_RETURN)))
            return GRP_CONTROL;
        return GRP_OPERATE;
    endfunction : oag_decode_group

endpackage : oag_pkg

`default_nettype wire

// >>> oag_rf_if.sv
// Interface between the address sequencer and its register file.
// Assumes both ends run on the same clock.
`default_nettype none

interface oag_rf_if;
    logic [2:0] rd_sel;
    logic [15:0] rd_data;
    logic wr_en;
    logic [2:0] wr_sel;
    logic [15:0] wr_data;

    modport ctrl(output rd_sel, output wr_en, output wr_sel,
                 output wr_data, input rd_data);
    modport store(input rd_sel, input wr_en, input wr_sel,
                  input wr_data, output rd_data);
endinterface : oag_rf_if

`default_nettype wire

// >>> oag_regfile.sv
// Eight general registers with a registered read port and one write port.
// Assumes the sequencer waits one cycle for read data.
`default_nettype none

module oag_regfile
    import oag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    oag_rf_if.store rf
);

    logic [15:0] regs [8];

    for (genvar i = 0; i < 8; i++) begin : g_reg
        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                regs[i] <= RESET_WORD;
            end else if (rf.wr_en && rf.wr_sel == 3'(i)) begin
                regs[i] <= rf.wr_data;
            end
        end
    end

    // Read returns the value before a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rf.rd_data <= RESET_WORD;
        end else begin
            rf.rd_data <= regs[rf.rd_sel];
        end
    end

endmodule : oag_regfile

`default_nettype wire

// >>> oag_top.sv
// Operand address generation: decodes an instruction, resolves source and
// destination operand addresses, steps pointer registers, pushes the stack.
// Assumes memory answers on the same clock with a one-cycle read ack.
`default_nettype none

// Function
// - Decode operation, register and addressing mode from each instruction
// - Register mode uses the register itself; results write back there
// - Pointer mode uses register contents as operand address
// - Auto modes step the register forward or backward per reference
// - Index mode adds the following word to the register for the address
// - Calls and traps use register six as hardware stack pointer
// - Single and double operand formats share the same addressing modes
// - Execution time is basic time plus operand addressing time
// - Mode zero adds nothing; other modes add their addressing time
// - Instructions are classed into five groups
// - Mode codes: register, autoincrement, autodecrement, index; low bit defers
// - Deferred auto modes always step by two
// - Program counter modes give immediate, absolute and relative operands
module oag_top
    import oag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] base_cycles,
    input wire logic wb_en,
    input wire logic [2:0] wb_sel,
    input wire logic [15:0] wb_data,
    input wire logic mem_rd_ack,
    input wire logic [15:0] mem_rd_data,
    output logic instr_ready,
    output logic mem_rd_req,
    output logic [15:0] mem_addr,
    output logic done,
    output oag_group_t group,
    output logic byte_op,
    output logic src_used,
    output logic src_is_reg,
    output logic [2:0] src_reg,
    output logic [15:0] src_addr,
    output logic dst_used,
    output logic dst_is_reg,
    output logic [2:0] dst_reg,
    output logic [15:0] dst_addr,
    output logic stack_used,
    output logic [15:0] stack_addr,
    output logic [15:0] exec_cycles
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_READ, ST_EVAL, ST_PC_READ, ST_IDX_ADDR,
        ST_IDX_WAIT, ST_PTR_WAIT, ST_PUSH_READ, ST_PUSH_EVAL, ST_DONE
    } oag_state_t;

    oag_state_t state;
    logic [15:0] ir;
    logic phase;
    logic [2:0] fld_mode;
    logic [2:0] fld_reg;
    logic [15:0] base_val;
    logic [15:0] exec_q;
    logic accept;
    oag_group_t dec_grp;
    logic dec_src, dec_dst, dec_push, dec_byte;
    logic [15:0] step, dec_val, sum_val;
    logic fld_done, fld_is_reg, go_ptr;
    logic [15:0] fld_addr, ptr_val;

    oag_rf_if rf();

    oag_regfile u_rf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .rf(rf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode

    assign accept = (state == ST_IDLE) && instr_valid;

    always_comb begin
        dec_grp = oag_decode_group(instr_word);
        dec_src = (dec_grp == GRP_DOUBLE);
        // Both formats feed the same 6-bit field layout
        dec_dst = (dec_grp == GRP_DOUBLE) || (dec_grp == GRP_SINGLE) ||
                  (!instr_word[15] && instr_word[11:6] == OPF_JMP) ||
                  (!instr_word[15] && instr_word[14:9] == OPF_CALL_TRAP);
        dec_push = (instr_word[14:9] == OPF_CALL_TRAP);
        dec_byte = instr_word[BYTE_BIT] && ((dec_grp == GRP_SINGLE) ||
                   (dec_grp == GRP_DOUBLE && instr_word[14:12] != OPF_SUB));
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand resolution datapath

    always_comb begin
        // Stack and program counter never go odd, so they step by words
        step = (fld_mode[DEFER_BIT] || !byte_op || fld_reg >= REG_SIX)
               ? STEP_WORD : STEP_BYTE;
        dec_val = rf.rd_data - step;
        sum_val = mem_rd_data + base_val;
        case (state)
            ST_PC_READ: rf.rd_sel = REG_PC;
            ST_PUSH_READ: rf.rd_sel = REG_SIX;
            default: rf.rd_sel = fld_reg;
        endcase
        rf.wr_en = 1'b0;
        rf.wr_sel = fld_reg;
        rf.wr_data = rf.rd_data;
        fld_done = 1'b0;
        fld_is_reg = 1'b0;
        fld_addr = rf.rd_data;
        go_ptr = 1'b0;
        ptr_val = rf.rd_data;
        case (state)
            ST_IDLE: begin
                rf.wr_en = wb_en;
                rf.wr_sel = wb_sel;
                rf.wr_data = wb_data;
            end
            ST_EVAL: begin
                case (fld_mode[2:1])
                    KIND_REG: begin
                        fld_done = 1'b1;
                        fld_is_reg = !fld_mode[DEFER_BIT];
                        if (!fld_mode[DEFER_BIT])
                            fld_addr = {13'h0000, fld_reg};
                    end
                    KIND_AINC: begin
                        rf.wr_en = 1'b1;
                        rf.wr_data = rf.rd_data + step;
                        go_ptr = fld_mode[DEFER_BIT];
                        fld_done = !fld_mode[DEFER_BIT];
                    end
                    KIND_ADEC: begin
                        rf.wr_en = 1'b1;
                        rf.wr_data = dec_val;
                        go_ptr = fld_mode[DEFER_BIT];
                        fld_done = !fld_mode[DEFER_BIT];
                        fld_addr = dec_val;
                        ptr_val = dec_val;
                    end
                    default: ;
                endcase
            end
            ST_IDX_ADDR: begin
                rf.wr_en = 1'b1;
                rf.wr_sel = REG_PC;
                rf.wr_data = rf.rd_data + STEP_WORD;
            end
            ST_IDX_WAIT: begin
                fld_addr = sum_val;
                ptr_val = sum_val;
                go_ptr = mem_rd_ack && fld_mode[DEFER_BIT];
                fld_done = mem_rd_ack && !fld_mode[DEFER_BIT];
            end
            ST_PTR_WAIT: begin
                fld_addr = mem_rd_data;
                fld_done = mem_rd_ack;
            end
            ST_PUSH_EVAL: begin
                rf.wr_en = 1'b1;
                rf.wr_sel = REG_SIX;
                rf.wr_data = rf.rd_data - STEP_WORD;
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= ST_IDLE;
            ir <= RESET_WORD;
            phase <= 1'b0;
            fld_mode <= 3'h0;
            fld_reg <= 3'h0;
            base_val <= RESET_WORD;
            exec_q <= RESET_WORD;
        end else begin
            case (state)
                ST_IDLE: if (accept) begin
                    ir <= instr_word;
                    phase <= !dec_src;
                    fld_mode <= dec_src ? instr_word[SRC_LSB+3 +: 3]
                                        : instr_word[DST_LSB+3 +: 3];
                    fld_reg <= dec_src ? instr_word[SRC_LSB +: 3]
                                       : instr_word[DST_LSB +: 3];
                    exec_q <= base_cycles
                        + (dec_src ? oag_addr_cycles(
                              instr_word[SRC_LSB+3 +: 3], 1'b0) : 16'h0000)
                        + (dec_dst ? oag_addr_cycles(
                              instr_word[DST_LSB+3 +: 3], 1'b1)
                              : 16'h0000);
                    state <= (dec_src || dec_dst) ? ST_READ
                           : (dec_push ? ST_PUSH_READ : ST_DONE);
                end
                ST_READ: state <= ST_EVAL;
                ST_EVAL: if (fld_mode[2:1] == KIND_INDEX) begin
                    base_val <= rf.rd_data;
                    state <= ST_PC_READ;
                end
                ST_PC_READ: state <= ST_IDX_ADDR;
                ST_IDX_ADDR: begin
                    // Relative addressing uses the already advanced counter
                    if (fld_reg == REG_PC)
                        base_val <= rf.rd_data + STEP_WORD;
                    state <= ST_IDX_WAIT;
                end
                ST_PUSH_READ: state <= ST_PUSH_EVAL;
                ST_PUSH_EVAL: state <= ST_DONE;
                ST_DONE: state <= ST_IDLE;
                default: ;
            endcase
            if (go_ptr)
                state <= ST_PTR_WAIT;
            if (fld_done) begin
                if (!phase && dst_used) begin
                    phase <= 1'b1;
                    fld_mode <= ir[DST_LSB+3 +: 3];
                    fld_reg <= ir[DST_LSB +: 3];
                    state <= ST_READ;
                end else begin
                    state <= stack_used ? ST_PUSH_READ : ST_DONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory read port

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mem_rd_req <= 1'b0;
            mem_addr <= RESET_WORD;
        end else if (state == ST_IDX_ADDR) begin
            mem_rd_req <= 1'b1;
            mem_addr <= rf.rd_data;
        end else if (go_ptr) begin
            mem_rd_req <= 1'b1;
            mem_addr <= ptr_val;
        end else if (mem_rd_ack) begin
            mem_rd_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            instr_ready <= 1'b1;
            done <= 1'b0;
            group <= GRP_OPERATE;
            byte_op <= 1'b0;
            src_used <= 1'b0;
            dst_used <= 1'b0;
            stack_used <= 1'b0;
            src_is_reg <= 1'b0;
            src_reg <= 3'h0;
            src_addr <= RESET_WORD;
            dst_is_reg <= 1'b0;
            dst_reg <= 3'h0;
            dst_addr <= RESET_WORD;
            stack_addr <= RESET_WORD;
            exec_cycles <= RESET_WORD;
        end else begin
            instr_ready <= (state == ST_DONE) ||
                           (state == ST_IDLE && !instr_valid);
            done <= (state == ST_DONE);
            if (state == ST_DONE)
                exec_cycles <= exec_q;
            if (accept) begin
                group <= dec_grp;
                byte_op <= dec_byte;
                src_used <= dec_src;
                dst_used <= dec_dst;
                stack_used <= dec_push;
            end
            if (fld_done && !phase) begin
                src_is_reg <= fld_is_reg;
                src_reg <= fld_reg;
                src_addr <= fld_addr;
            end
            if (fld_done && phase) begin
                dst_is_reg <= fld_is_reg;
                dst_reg <= fld_reg;
                dst_addr <= fld_addr;
            end
            if (state == ST_PUSH_EVAL)
                stack_addr <= rf.rd_data - STEP_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_decode;
        done |-> group == oag_decode_group(ir);
    endproperty
    a_decode: assert property (p_decode) else $error("bad group");

    property p_fields;
        done && src_used |-> src_reg == ir[SRC_LSB +: 3] &&
            src_is_reg == (ir[SRC_LSB+3 +: 3] == 3'h0);
    endproperty
    a_fields: assert property (p_fields) else $error("bad src");

    property p_acc;
        done && dst_used && dst_is_reg |-> dst_addr == {13'h0000, dst_reg};
    endproperty
    a_acc: assert property (p_acc) else $error("bad reg operand");

    property p_ptr;
        state == ST_EVAL && fld_mode == 3'h1 |-> fld_done && !fld_is_reg
            && fld_addr == rf.rd_data;
    endproperty
    a_ptr: assert property (p_ptr) else $error("bad pointer");

    property p_ainc;
        state == ST_EVAL && fld_mode == 3'h2 && fld_reg < REG_SIX
            |-> rf.wr_en && rf.wr_data == rf.rd_data + (byte_op ? 2'h1 : 2'h2);
    endproperty
    a_ainc: assert property (p_ainc) else $error("bad step");

    property p_adef;
        state == ST_EVAL && fld_mode == 3'h5 |-> rf.wr_data ==
            rf.rd_data - 2'h2 ##1 state == ST_PTR_WAIT && mem_rd_req;
    endproperty
    a_adef: assert property (p_adef) else $error("bad defer dec");

    property p_adec;
        state == ST_EVAL && fld_mode == 3'h4 |-> fld_addr == rf.wr_data;
    endproperty
    a_adec: assert property (p_adec) else $error("bad autodec");

    property p_index;
        state == ST_IDX_WAIT && mem_rd_ack && !fld_mode[0]
            |=> $past(mem_rd_data) + $past(base_val) ==
                ($past(phase) ? dst_addr : src_addr);
    endproperty
    a_index: assert property (p_index) else $error("bad index");

    property p_pcword;
        state == ST_IDX_ADDR |-> rf.wr_sel == REG_PC &&
            rf.wr_data == rf.rd_data + 2'h2 ##1 mem_addr == $past(rf.rd_data);
    endproperty
    a_pcword: assert property (p_pcword) else $error("bad pc");

    property p_push;
        state == ST_PUSH_EVAL |-> rf.wr_sel == REG_SIX ##1
            stack_addr == $past(rf.rd_data) - 2'h2 ##1 done;
    endproperty
    a_push: assert property (p_push) else $error("bad push");

    property p_same_fmt;
        accept && dec_grp == GRP_SINGLE |=> fld_mode ==
            $past(instr_word[DST_LSB+3 +: 3]) && phase;
    endproperty
    a_same_fmt: assert property (p_same_fmt) else $error("bad fmt");

    property p_mode0;
        state == ST_DONE && (!src_used || ir[11:9] == 3'h0) &&
            (!dst_used || ir[5:3] == 3'h0) |=> exec_cycles == $past(exec_q);
    endproperty
    a_mode0: assert property (p_mode0) else $error("bad time");

    property p_time;
        accept && dec_dst && instr_word[5:3] == 3'h7 && !dec_src
            |=> exec_q == $past(base_cycles) + 16'h0497;
    endproperty
    a_time: assert property (p_time) else $error("bad time sum");

    property p_regmode;
        state == ST_EVAL && fld_mode == 3'h0 |-> fld_is_reg && !rf.wr_en;
    endproperty
    a_regmode: assert property (p_regmode) else $error("bad mode0");

    c_double: cover property (done && group == GRP_DOUBLE && !src_is_reg);
    c_push: cover property (state == ST_PUSH_EVAL);
    c_idxdef: cover property (state == ST_PTR_WAIT && fld_mode == 3'h7);

endmodule : oag_top

`default_nettype wire

// >>> oag_mem_model.sv
// Memory model for oag_top: answers reads after a chosen latency.
// Assumes one outstanding read and a request held until after the ack.
`default_nettype none
module oag_mem_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mem_rd_req,
    input wire logic [15:0] mem_addr,
    input wire logic [2:0] lat,
    output logic mem_rd_ack,
    output logic [15:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] wait_cnt;
    ////////////////////////////////////////////////////////////
    // Contents are the inverted address so the bench can predict them.
    // Outside an ack the data toggles, so stale data never looks valid.
    always @(posedge clk_sys) begin
        mem_rd_ack <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        if (!resetn) begin
            wait_cnt <= 3'h0;
            mem_rd_data <= 16'h0000;
        end else if (mem_rd_req && !mem_rd_ack) begin
            if (wait_cnt >= lat) begin
                mem_rd_ack <= 1'b1;
                mem_rd_data <= ~mem_addr;
                wait_cnt <= 3'h0;
            end else begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule : oag_mem_model
`default_nettype wire

// >>> tb_operand_address_generation.sv
// Testbench for oag_top: predicts operand addresses from a register
// model and compares them when done pulses.
// Assumes oag_mem_model returns the inverted address as read data.
`default_nettype none
module tb_operand_address_generation
    import oag_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        oag_group_t grp;
        logic bo, su, du, ku, sr, dr;
        logic [2:0] rs, rd;
        logic [15:0] sa, da, ka, ex;
    } oag_exp_t;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] base_cycles = 16'h0000;
    logic wb_en = 1'b0;
    logic [2:0] wb_sel = 3'h0;
    logic [15:0] wb_data = 16'h0000;
    logic [2:0] lat = 3'h0;
    logic mem_rd_ack, instr_ready, mem_rd_req, done, byte_op;
    logic [15:0] mem_rd_data, mem_addr, src_addr, dst_addr;
    logic [15:0] stack_addr, exec_cycles;
    logic src_used, src_is_reg, dst_used, dst_is_reg, stack_used;
    logic [2:0] src_reg, dst_reg;
    oag_group_t group;
    logic [3:0] flags_seen, src_sel, dst_sel;
    logic [5:0] reset_view;
    logic [15:0] rr [8];
    logic [31:0] seed = 32'h0000C368;
    oag_exp_t expq [$];
    int fail_count = 0;
    int check_count = 0;
    int st [8] = '{0, 225, 225, 600, 225, 600, 600, 850};
    int dt [8] = '{0, 600, 600, 850, 600, 850, 850, 1175};
    logic [15:0] gw [4] = '{16'h0000, 16'h0100, 16'h00A1, 16'h7000};
    oag_group_t gg [4] = '{GRP_OPERATE, GRP_CONTROL, GRP_CCODE, GRP_OPERATE};
    assign flags_seen = {byte_op, src_used, dst_used, stack_used};
    assign src_sel = {src_is_reg, src_reg};
    assign dst_sel = {dst_is_reg, dst_reg};
    assign reset_view = {instr_ready, done, mem_rd_req, group};
    always #2 clk_sys = ~clk_sys;
    oag_top dut (
        .clk_sys, .resetn, .instr_valid, .instr_word, .base_cycles,
        .wb_en, .wb_sel, .wb_data, .mem_rd_ack, .mem_rd_data,
        .instr_ready, .mem_rd_req, .mem_addr, .done, .group, .byte_op,
        .src_used, .src_is_reg, .src_reg, .src_addr, .dst_used,
        .dst_is_reg, .dst_reg, .dst_addr, .stack_used, .stack_addr,
        .exec_cycles
    );
    oag_mem_model mem (
        .clk_sys, .resetn, .mem_rd_req, .mem_addr, .lat, .mem_rd_ack,
        .mem_rd_data
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Resolves one operand field and steps the register model
    function automatic void res(input logic [5:0] f, input logic bo,
                                output logic isr, output logic [15:0] a);
        logic [2:0] m;
        logic [2:0] r;
        logic [15:0] sz;
        m = f[5:3];
        r = f[2:0];
        sz = (m[0] || !bo || r[2:1] == 2'h3) ? 16'h0002 : 16'h0001;
        isr = (m == 3'h0);
        a = rr[r];
        case (m[2:1])
            2'h0: if (isr) a = {13'h0000, r};
            2'h1: rr[r] = rr[r] + sz;
            2'h2: begin
                rr[r] = rr[r] - sz;
                a = rr[r];
            end
            default: begin
                a = ~rr[7];
                rr[7] = rr[7] + 16'h0002;
                a = a + rr[r];
            end
        endcase
        if (m[0] && m != 3'h1)
            a = ~a;
    endfunction : res
    task automatic chk(input string nm, input logic [15:0] ex, got);
        check_count++;
        if (got !== ex) begin
            fail_count++;
            $display("wrong value: %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (instr_ready !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            fail_count++;
            $display("wrong value: instr_ready expected 1 seen %b", instr_ready);
            give_verdict();
        end
    endtask : wait_ready
    task automatic wb(input logic [2:0] r, input logic [15:0] d);
        wb_en = 1'b1;
        wb_sel = r;
        wb_data = d;
        @(posedge clk_sys);
        #1;
        rr[r] = d;
    endtask : wb
    // Offers one instruction, then junk while busy, which must be ignored
    task automatic issue(input logic [15:0] w, input oag_group_t g,
                         input logic bo, su, du, ku);
        oag_exp_t e;
        logic [31:0] x;
        x = rnd();
        e = '{grp: g, bo: bo, su: su, du: du, ku: ku, rs: w[8:6],
              rd: w[2:0], ex: {8'h00, x[7:0]}, default: '0};
        base_cycles = e.ex;
        lat = x[10:8];
        if (su) begin
            res(w[11:6], bo, e.sr, e.sa);
            e.ex = e.ex + 16'(st[w[11:9]]);
        end
        if (du) begin
            res(w[5:0], bo, e.dr, e.da);
            e.ex = e.ex + 16'(dt[w[5:3]]);
        end
        if (ku) begin
            rr[6] = rr[6] - 16'h0002;
            e.ka = rr[6];
        end
        expq.push_back(e);
        instr_word = w;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        instr_word = ~w;
        wb_en = 1'b1;
        wb_sel = x[13:11];
        wb_data = x[31:16];
        @(posedge clk_sys);
        #1;
        instr_valid = 1'b0;
        wb_en = 1'b0;
        wait_ready();
    endtask : issue
    ////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin : watch
        oag_exp_t e;
        if (done === 1'b1) begin
            if (expq.size() == 0) begin
                fail_count++;
                $display("wrong value: done expected 0 seen 1");
            end else begin
                e = expq.pop_front();
                chk("group", 16'(e.grp), 16'(group));
                chk("flags", 16'({e.bo, e.su, e.du, e.ku}), 16'(flags_seen));
                if (e.su) begin
                    chk("src_sel", 16'({e.sr, e.rs}), 16'(src_sel));
                    chk("src_addr", e.sa, src_addr);
                end
                if (e.du) begin
                    chk("dst_sel", 16'({e.dr, e.rd}), 16'(dst_sel));
                    chk("dst_addr", e.da, dst_addr);
                end
                if (e.ku)
                    chk("stack_addr", e.ka, stack_addr);
                chk("exec_cycles", e.ex, exec_cycles);
            end
        end
    end
    initial begin : main
        logic [31:0] x;
        for (int i = 0; i < 8; i++) begin
            rr[i] = 16'h0000;
        end
        repeat (20) @(posedge clk_sys);
        #1;
        chk("reset_out", 16'({3'h4, GRP_OPERATE}), 16'(reset_view));
        resetn = 1'b1;
        @(posedge clk_sys);
        #1;
        // Registers still at reset value zero
        issue(16'h148B, GRP_DOUBLE, 1'b0, 1'b1, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            issue(gw[k], gg[k], 1'b0, 1'b0, 1'b0, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            x = rnd();
            wb(3'(i), x[15:0]);
        end
        for (int i = 0; i < 150; i++) begin
            x = rnd();
            if (x[20])
                wb(x[23:21], x[31:16]);
            case (x[18:16])
                3'h0: issue({x[15], 3'h1, x[11:0]}, GRP_DOUBLE, x[15], 1'b1,
                            1'b1, 1'b0);
                3'h1: issue({4'hE, x[11:0]}, GRP_DOUBLE, 1'b0, 1'b1, 1'b1, 1'b0);
                3'h2: issue({x[15], 9'h028, x[5:0]}, GRP_SINGLE, x[15], 1'b0,
                            1'b1, 1'b0);
                3'h3: issue({7'h04, x[8:0]}, GRP_CONTROL, 1'b0, 1'b0, 1'b1, 1'b1);
                3'h4: issue({7'h44, x[8:0]}, GRP_CONTROL, 1'b0, 1'b0, 1'b0, 1'b1);
                3'h5: issue({10'h001, x[5:0]}, GRP_CONTROL, 1'b0, 1'b0, 1'b1,
                            1'b0);
                default: issue(gw[x[1:0]], gg[x[1:0]], 1'b0, 1'b0, 1'b0, 1'b0);
            endcase
        end
        repeat (4) @(posedge clk_sys);
        if (expq.size() != 0) begin
            fail_count++;
            $display("wrong value: pending expected 0 seen %0d", expq.size());
        end
        give_verdict();
    end
endmodule : tb_operand_address_generation
`default_nettype wire
